/* rtl/i2sw_pkg.sv */
package i2sw_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   // Least low time on the reset pin before it takes effect.
   localparam int RST_MIN_NS = 500;
   localparam int RST_MIN_CYC_I = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_MIN_CYC = 4'(RST_MIN_CYC_I < 1 ? 1 : RST_MIN_CYC_I);
   // Samples that must agree before a filtered line changes.
   localparam int FILT_LEN = 3;

   // ------------------------------------------------------------
   // Protocol layout
   // ------------------------------------------------------------
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ADDR_FIXED = 4'he;
   localparam int RW_BIT = 0;
   localparam int CHAN_NUM = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK,
      ST_IGNORE
   } i2sw_state_t;
endpackage

/* rtl/i2sw_cap_if.sv */
`timescale 1ns/100ps
interface i2sw_cap_if;
   logic [7:0] rx_byte;
   modport link (output rx_byte);
   modport core (input rx_byte);
endinterface

/* rtl/i2sw_link_rx.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Serial-clock domain shifter
// ------------------------------------------------------------
// The shifter holds no control state, so it needs no reset. Its word is
// read by the core only after a falling clock edge, while it is frozen
// until the next rising edge.
module i2sw_link_rx
   import i2sw_pkg::*;
(
   input wire logic scl,            // serial clock, link domain
   input wire logic sda_in,         // serial data line level
   i2sw_cap_if.link cap             // last eight captured bits
);
   always_ff @(posedge scl) begin
      cap.rx_byte <= {cap.rx_byte[6:0], sda_in};
   end
endmodule // i2sw_link_rx

/* rtl/i2sw_switch_ctrl.sv */
`timescale 1ns/100ps
module i2sw_switch_ctrl
   import i2sw_pkg::*;
(
   input wire logic core_clk,             // core clock
   input wire logic srst,                 // synchronous reset, power-on
   input wire logic scl,                  // serial clock pin, link clock
   input wire logic sda_in,               // serial data pin level
   output logic sda_out,                  // serial data drive level
   output logic sda_oe,                   // serial data pull-down enable
   input wire logic rst_n,                // reset pin, active low
   input wire logic [2:0] addr_pin,       // address select pins
   output logic [CHAN_NUM-1:0] chan_en    // downstream_pair enables
);
   // ------------------------------------------------------------
   // Input synchronisers and filters
   // ------------------------------------------------------------
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic [1:0] line_f_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic [3:0] rst_cnt_reg;
   logic rst_hold_reg;

   always_ff @(posedge core_clk) begin
      pin_s1_reg <= {addr_pin, rst_n, sda_in, scl};
      pin_s2_reg <= pin_s1_reg;
   end

   // Filtering rejects single-sample glitches on the slow bus lines.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic [FILT_LEN-1:0] hist_reg;
         wire all_hi = &hist_reg;
         wire all_lo = ~|hist_reg;
         always_ff @(posedge core_clk) begin
            hist_reg <= {hist_reg[FILT_LEN-2:0], pin_s2_reg[gi]};
            if (srst) begin
               line_f_reg[gi] <= 1'b1;
            end else if (all_hi || all_lo) begin
               line_f_reg[gi] <= all_hi;
            end
         end
      end
   endgenerate

   wire scl_f = line_f_reg[0];
   wire sda_f = line_f_reg[1];
   wire rst_pin_low = ~pin_s2_reg[2];
   wire [2:0] addr_s = pin_s2_reg[5:3];

   always_ff @(posedge core_clk) begin
      scl_prev_reg <= srst ? 1'b1 : scl_f;
      sda_prev_reg <= srst ? 1'b1 : sda_f;
   end

   // ------------------------------------------------------------
   // Bus events
   // ------------------------------------------------------------
   wire scl_rise = scl_f && !scl_prev_reg;
   wire scl_fall = !scl_f && scl_prev_reg;
   wire start_ev = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
   wire stop_ev = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;

   // The reset pin acts only after it has stayed low for the least width.
   always_ff @(posedge core_clk) begin
      if (srst || !rst_pin_low) begin
         rst_cnt_reg <= 4'h0;
         rst_hold_reg <= 1'b0;
      end else begin
         if (rst_cnt_reg != RST_MIN_CYC) begin
            rst_cnt_reg <= rst_cnt_reg + 4'h1;
         end
         rst_hold_reg <= (rst_cnt_reg + 4'h1 >= RST_MIN_CYC);
      end
   end

   wire rst_all = srst || rst_hold_reg;

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   i2sw_cap_if cap ();

   i2sw_link_rx u_link_rx (
      .scl(scl),
      .sda_in(sda_in),
      .cap(cap.link)
   );

   i2sw_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] tx_reg, tx_next;
   logic pend_reg, pend_next;
   logic rw_reg, rw_next;
   logic nack_reg, nack_next;
   logic oe_reg, oe_next;
   logic [CHAN_NUM-1:0] chan_reg, chan_next;
   logic sda_out_reg;

   wire byte_end = scl_fall && (cnt_reg == BYTE_BITS);
   wire cnt_inc = scl_rise && (cnt_reg < BYTE_BITS);
   wire addr_hit = (cap.rx_byte[7:1] == {ADDR_FIXED[3:0], addr_s});
   wire rd_req = cap.rx_byte[RW_BIT];

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_inc ? cnt_reg + 4'h1 : cnt_reg;
      ctrl_next = ctrl_reg;
      tx_next = tx_reg;
      pend_next = pend_reg;
      rw_next = rw_reg;
      nack_next = nack_reg;
      oe_next = oe_reg;
      chan_next = chan_reg;
      if (start_ev) begin
         state_next = ST_ADDR;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (stop_ev) begin
         state_next = ST_IDLE;
         oe_next = 1'b0;
         pend_next = 1'b0;
         if (pend_reg) begin
            chan_next = ctrl_reg[CHAN_NUM-1:0];
         end
      end else begin
         case (state_reg)
            ST_ADDR: begin
               if (byte_end && addr_hit) begin
                  state_next = ST_ADDR_ACK;
                  oe_next = 1'b1;
                  rw_next = rd_req;
               end else if (byte_end) begin
                  state_next = ST_IGNORE;
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall && rw_reg) begin
                  state_next = ST_RD_DATA;
                  cnt_next = 4'h0;
                  tx_next = ctrl_reg;
                  oe_next = !ctrl_reg[7];
               end else if (scl_fall) begin
                  state_next = ST_WR_DATA;
                  cnt_next = 4'h0;
                  oe_next = 1'b0;
               end
            end
            ST_WR_DATA: begin
               if (byte_end) begin
                  state_next = ST_WR_ACK;
                  ctrl_next = cap.rx_byte;
                  pend_next = 1'b1;
                  oe_next = 1'b1;
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  state_next = ST_WR_DATA;
                  cnt_next = 4'h0;
                  oe_next = 1'b0;
               end
            end
            ST_RD_DATA: begin
               if (byte_end) begin
                  state_next = ST_RD_ACK;
                  oe_next = 1'b0;
               end else if (scl_fall) begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  oe_next = !tx_reg[6];
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  nack_next = sda_f;
               end
               if (scl_fall && nack_reg) begin
                  state_next = ST_IGNORE;
                  oe_next = 1'b0;
               end else if (scl_fall) begin
                  state_next = ST_RD_DATA;
                  cnt_next = 4'h0;
                  tx_next = ctrl_reg;
                  oe_next = !ctrl_reg[7];
               end
            end
            default: begin
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst_all) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         ctrl_reg <= CTRL_RESET;
         tx_reg <= 8'h00;
         pend_reg <= 1'b0;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         oe_reg <= 1'b0;
         chan_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ctrl_reg <= ctrl_next;
         tx_reg <= tx_next;
         pend_reg <= pend_next;
         rw_reg <= rw_next;
         nack_reg <= nack_next;
         oe_reg <= oe_next;
         chan_reg <= chan_next;
      end
      sda_out_reg <= 1'b0;
   end

   assign sda_oe = oe_reg;
   assign sda_out = sda_out_reg;
   assign chan_en = chan_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence wr_byte_taken;
      state_reg == ST_WR_DATA && byte_end && !start_ev && !stop_ev && !rst_all;
   endsequence

   sequence stop_seen;
      stop_ev && !rst_all;
   endsequence

   pin_reset_a: assert property (
      rst_hold_reg |=> chan_en == '0 && state_reg == ST_IDLE)
      else $error("reset pin did not clear the switch");
   por_clear_a: assert property (
      disable iff (1'b0) srst |=> chan_en == '0 && ctrl_reg == 8'h00)
      else $error("power-on reset left state");
   start_det_a: assert property (
      start_ev && !rst_all |=> state_reg == ST_ADDR && cnt_reg == 4'h0)
      else $error("start not taken");
   stop_det_a: assert property (stop_seen |=> state_reg == ST_IDLE && !sda_oe)
      else $error("stop not taken");
   chan_commit_a: assert property (
      !$stable(chan_en) |-> $past(stop_ev) || $past(rst_all))
      else $error("channels changed away from a stop");
   last_byte_a: assert property (
      wr_byte_taken |=> ctrl_reg == $past(cap.rx_byte) && pend_reg)
      else $error("last written byte not stored");
   commit_value_a: assert property (
      stop_seen ##0 pend_reg |=> chan_en == $past(ctrl_reg[CHAN_NUM-1:0]))
      else $error("stored selection not committed at stop");
   ack_drive_a: assert property (
      (state_reg == ST_WR_ACK || state_reg == ST_ADDR_ACK) |-> sda_oe)
      else $error("acknowledge not driven");
   nack_release_a: assert property (state_reg == ST_IGNORE |-> !sda_oe)
      else $error("data line held after no acknowledge");
   bit_count_a: assert property (
      cnt_inc && !start_ev && !stop_ev && !rst_all
      |=> cnt_reg == $past(cnt_reg) + 4'h1)
      else $error("bit count slipped");
   dir_select_a: assert property (
      state_reg == ST_ADDR_ACK && scl_fall && !start_ev && !stop_ev && !rst_all
      |=> state_reg == (rw_reg ? ST_RD_DATA : ST_WR_DATA))
      else $error("direction bit misread");
endmodule // i2sw_switch_ctrl

/* dv/i2sw_master_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Upstream bus master
// ------------------------------------------------------------
// Phases are 1 us long, so the device answer about 0.7 us after a
// falling clock edge has settled before this master samples or drives.
module i2sw_master_model (
   output logic scl,      // serial clock, only this master drives it
   output logic sda_oe,   // pulls the data line low when high
   input wire logic sda   // resolved data line level
);
   localparam int Q = 1000;
   // Every step lands this far after a core clock edge, so that no line
   // change races the core's sampling edge.
   localparam int SKEW = 37;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic start_cond();
      #(Q + SKEW) sda_oe = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop_cond();
      #Q sda_oe = 1'b1;
      #Q scl = 1'b1;
      #Q sda_oe = 1'b0;
      #Q;
   endtask
   task automatic bit_io(input logic b, output logic s);
      #Q sda_oe = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
   endtask
   // Eight data bits MSB first, then the ninth (acknowledge) bit.
   task automatic byte_io(input logic [7:0] tx, input logic ninth_tx,
                          output logic [7:0] rx, output logic ninth_rx);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ninth_tx, ninth_rx);
   endtask
endmodule // i2sw_master_model

/* dv/i2c_channel_switch_reset_tb_top.sv */
`timescale 1ns/100ps
module i2c_channel_switch_reset_tb_top;
   import i2sw_pkg::*;
   localparam logic [2:0] PIN_V = 3'h5;
   localparam logic [7:0] WR_ADDR = {ADDR_FIXED[3:0], PIN_V, 1'b0};
   localparam logic [7:0] RD_ADDR = {ADDR_FIXED[3:0], PIN_V, 1'b1};
   logic core_clk;
   logic srst;
   logic rst_n;
   logic [2:0] addr_pin;
   wire scl;
   wire m_oe;
   wire sda_out;
   wire sda_oe;
   wire sda_line;
   wire [CHAN_NUM-1:0] chan_en;
   int bad_count = 0;
   int n_tests = 0;
   // Pull-up on the data line: any party pulling makes it low.
   assign sda_line = ~(m_oe | (sda_oe & ~sda_out));
   i2sw_switch_ctrl i2sw_switch_ctrl_inst (.core_clk(core_clk), .srst(srst), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .rst_n(rst_n),
      .addr_pin(addr_pin), .chan_en(chan_en));
   i2sw_master_model i2sw_master_model_inst (.scl(scl), .sda_oe(m_oe), .sda(sda_line));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ntx, input logic [7:0] exp,
                       input logic nexp, input string msg);
      logic [7:0] rx;
      logic n;
      i2sw_master_model_inst.byte_io(tx, ntx, rx, n);
      if (tx === 8'hff) begin
         chk(rx, exp, msg);
      end
      chk({7'h00, n}, {7'h00, nexp}, {msg, " ninth bit"});
   endtask
   task automatic write_txn(input logic [7:0] d0, input logic [7:0] d1, input int n,
                            input logic [3:0] prev);
      i2sw_master_model_inst.start_cond();
      xfer(WR_ADDR, 1'b1, 8'h00, 1'b0, "address ack");
      for (int i = 0; i < n; i++) begin
         xfer(i == 0 ? d0 : d1, 1'b1, 8'h00, 1'b0, "data ack");
      end
      chk({4'h0, chan_en}, {4'h0, prev}, "enables before stop");
      i2sw_master_model_inst.stop_cond();
      repeat (10) @(posedge core_clk);
   endtask
   task automatic read_txn(input logic [7:0] exp);
      i2sw_master_model_inst.start_cond();
      xfer(RD_ADDR, 1'b1, 8'h00, 1'b0, "read address ack");
      xfer(8'hff, 1'b0, exp, 1'b0, "first read byte");
      xfer(8'hff, 1'b1, exp, 1'b1, "last read byte");
      i2sw_master_model_inst.stop_cond();
      repeat (10) @(posedge core_clk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power_on();
      chk({4'h0, chan_en}, 8'h00, "power-on enables");
      chk({7'h00, sda_oe}, 8'h00, "power-on data drive");
      chk({7'h00, sda_out}, 8'h00, "data drive level");
      $display("test power_on finished");
   endtask
   task automatic t_writes();
      write_txn(8'h5a, 8'h00, 1, 4'h0);
      chk({4'h0, chan_en}, 8'h0a, "single write");
      write_txn(8'h03, 8'hbc, 2, 4'ha);
      chk({4'h0, chan_en}, 8'h0c, "last byte kept");
      read_txn(8'hbc);
      $display("test writes finished");
   endtask
   task automatic t_foreign();
      i2sw_master_model_inst.start_cond();
      xfer(WR_ADDR ^ 8'h02, 1'b1, 8'h00, 1'b1, "foreign address");
      xfer(8'h0f, 1'b1, 8'h00, 1'b1, "foreign data");
      i2sw_master_model_inst.stop_cond();
      repeat (10) @(posedge core_clk);
      chk({4'h0, chan_en}, 8'h0c, "foreign write ignored");
      $display("test foreign finished");
   endtask
   task automatic t_resets();
      rst_n <= 1'b0;
      repeat (15) @(posedge core_clk);
      chk({4'h0, chan_en}, 8'h00, "pin reset");
      rst_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      read_txn(8'h00);
      write_txn(8'h05, 8'h00, 1, 4'h0);
      chk({4'h0, chan_en}, 8'h05, "write after pin reset");
      srst <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk({4'h0, chan_en}, 8'h00, "power-on reset mid-run");
      srst <= 1'b0;
      repeat (10) @(posedge core_clk);
      read_txn(8'h00);
      $display("test resets finished");
   endtask
   initial begin
      srst = 1'b1;
      rst_n = 1'b1;
      addr_pin = PIN_V;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      repeat (10) @(posedge core_clk);
      t_power_on();
      t_writes();
      t_foreign();
      t_resets();
      stop_test();
   end
   // The run needs about 0.7 ms; seven times that means a hang.
   initial begin
      #5000000;
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      stop_test();
   end
endmodule // i2c_channel_switch_reset_tb_top
